// file: hw/mac_reset_init_pkg.sv
// Constants shared by the MAC reset and bring-up control block
package mac_reset_init_pkg;

	// ****************************************
	// Register bus geometry
	// ****************************************
	localparam int          ADDR_W          = 14;
	localparam int          DATA_W          = 32;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [13:0] OFF_CORE_RESET  = 14'h0000;
	localparam logic [13:0] OFF_MAC_STATE   = 14'h0004;
	localparam logic [13:0] OFF_GLOBAL_IRQ  = 14'h0008;
	localparam logic [13:0] OFF_IRQ_PACE    = 14'h000C;
	localparam logic [13:0] OFF_MGMT_CTRL   = 14'h0010;
	localparam logic [13:0] OFF_MGMT_ALIVE  = 14'h0014;
	localparam logic [13:0] OFF_MAC_CTRL    = 14'h0018;
	localparam logic [13:0] OFF_RX_CTRL     = 14'h001C;
	localparam logic [13:0] OFF_TX_CTRL     = 14'h0020;
	localparam logic [13:0] OFF_DESC_BASE   = 14'h2000;

	// ****************************************
	// Descriptor RAM: 8K bytes of 32-bit words
	// ****************************************
	localparam int          DESC_BYTES      = 8192;
	localparam int          DESC_WORDS      = DESC_BYTES / 4;
	localparam int          DESC_IDX_W      = 11;

	// ****************************************
	// Field positions and widths
	// ****************************************
	localparam int          CORE_RST_BIT    = 0;
	localparam int          GIRQ_EN_BIT     = 0;
	localparam int          MGMT_EN_BIT     = 30;
	localparam int          MGMT_NOPRE_BIT  = 20;
	localparam int          MGMT_DIV_W      = 16;
	localparam int          MEDIA_EN_BIT    = 5;
	localparam int          DMA_EN_BIT      = 0;
	localparam int          ERR_FLAG_BIT    = 31;
	localparam int          ERR_CODE_W      = 8;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] MGMT_DIV_RST    = 16'h00FF;
	localparam logic [31:0] PACE_RST        = 32'h0000_0000;
	localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

	// ****************************************
	// Management frame layout and timing
	// ****************************************
	localparam int          PHY_COUNT       = 32;
	localparam logic [5:0]  FRAME_TOP       = 6'h3F;
	localparam logic [5:0]  FRAME_NOPRE_TOP = 6'h1F;
	localparam logic [5:0]  FRAME_TA_HI     = 6'h11;
	localparam logic [5:0]  FRAME_DATA_HI   = 6'h0F;
	localparam logic [4:0]  POLL_REG        = 5'h01;
	localparam logic [15:0] PHY_ABSENT      = 16'hFFFF;
	localparam int          MGMT_MAX_HZ     = 1_000_000;
	localparam int          MGMT_READ_US    = 50;

endpackage

// file: hw/mgmt_link_if.sv
// Control and status bundle between the register block and poll engine
`timescale 1ns/1ps
interface mgmt_link_if;
	logic        enable;      // Engine enable
	logic [15:0] divider;     // Clock divider
	logic        no_preamble; // Skip access preamble
	logic [31:0] alive;       // One bit per detected PHY
	logic [4:0]  poll_addr;   // Address being polled

	modport ctrl   (output enable, divider, no_preamble,
			input alive, poll_addr);
	modport engine (input enable, divider, no_preamble,
			output alive, poll_addr);
endinterface

// file: hw/mgmt_poll_engine.sv
// Management-serial engine that polls every PHY address for presence
`timescale 1ns/1ps
module mgmt_poll_engine
	import mac_reset_init_pkg::*;
(
	input  wire logic clk_sys,   // System clock
	input  wire logic nrst,      // Synchronous reset, low
	mgmt_link_if.engine lnk,     // Control and status
	input  wire logic mdio_in,   // Data pin in
	output logic      mdio_out,  // Data pin out
	output logic      mdio_oe,   // Data pin drive enable
	output logic      mdc        // Management clock
);
	typedef enum logic {ST_IDLE, ST_SHIFT} eng_state_type;

	eng_state_type state_ff;     // Engine state
	logic        mdi_s1_ff;      // Pin sync stage one
	logic        mdi_s2_ff;      // Pin sync stage two
	logic [15:0] div_ff;         // Divider count
	logic        mdc_ff;         // Clock level
	logic [5:0]  bit_ff;         // Frame bit index
	logic [4:0]  addr_ff;        // Polled address
	logic [15:0] data_ff;        // Shifted read data
	logic [31:0] alive_ff;       // Presence map
	logic        out_ff;         // Driven data bit
	logic        oe_ff;          // Drive enable

	// ****************************************
	// Decode
	// ****************************************
	wire         tick   = lnk.enable && (div_ff == lnk.divider);
	wire         fall   = tick && mdc_ff;
	wire         rise   = tick && !mdc_ff;
	wire [63:0]  frame  = {32'hFFFF_FFFF, 2'b01, 2'b10, addr_ff,
				POLL_REG, 18'h00000};
	wire [5:0]   start  = lnk.no_preamble ? FRAME_NOPRE_TOP
					  : FRAME_TOP;
	wire         last   = (bit_ff == 6'h00);
	wire [15:0]  nxt_data = {data_ff[14:0], mdi_s2_ff};

	assign mdc           = mdc_ff;
	assign mdio_out      = out_ff;
	assign mdio_oe       = oe_ff;
	assign lnk.alive     = alive_ff;
	assign lnk.poll_addr = addr_ff;

	// Two flops before any logic looks at the pin
	always_ff @(posedge clk_sys) begin
		mdi_s1_ff <= nrst ? mdio_in : 1'b0;
		mdi_s2_ff <= nrst ? mdi_s1_ff : 1'b0;
	end

	// Divider: one enable pulse per half period of the clock
	always_ff @(posedge clk_sys) begin
		if (!nrst || !lnk.enable || tick) begin
			div_ff <= 16'h0000;
		end else begin
			div_ff <= div_ff + 16'h0001;
		end
	end

	// One read in flight at a time; a full frame is slow, so
	// software is expected to sample the map, not spin on it
	always_ff @(posedge clk_sys) begin
		if (!nrst || !lnk.enable) begin
			state_ff <= ST_IDLE;
			mdc_ff   <= 1'b0;
			bit_ff   <= FRAME_TOP;
			addr_ff  <= 5'h00;
			data_ff  <= 16'h0000;
			alive_ff <= 32'h0000_0000;
			out_ff   <= 1'b1;
			oe_ff    <= 1'b0;
		end else begin
			if (tick) begin
				mdc_ff <= !mdc_ff;
			end
			unique case (state_ff)
				ST_IDLE: begin
					// Open a frame on a falling edge so its
					// first bit is driven, not skipped
					if (fall) begin
						out_ff   <= frame[start];
						oe_ff    <= 1'b1;
						bit_ff   <= start;
						state_ff <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (fall) begin
						// Drive on the falling edge
						out_ff <= frame[bit_ff];
						oe_ff  <= bit_ff > FRAME_TA_HI;
					end else if (rise) begin
						if (bit_ff <= FRAME_DATA_HI) begin
							data_ff <= nxt_data;
						end
						if (last) begin
							// Walk all 32 addresses
							alive_ff[addr_ff] <=
								nxt_data != PHY_ABSENT;
							addr_ff  <= addr_ff + 5'h01;
							state_ff <= ST_IDLE;
						end else begin
							bit_ff <= bit_ff - 6'h01;
						end
					end
				end
			endcase
		end
	end
endmodule

// file: hw/mac_reset_init_control.sv
// Reset, enable gating, interrupt pacing and bring-up registers of a MAC
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Overview of operation
// - Writing one resets core to defaults
// - Core reset waits for both DMAs idle
// - Reset bit reads one until done
// - Soft reset touches only core registers
// - Hardware reset and enable give defaults
// - Descriptor error latched until hardware reset
// - Disabled: writes ignored, reads zero
// - Pace counter spaces back-to-back interrupts
// - Local 8K descriptor RAM in wrapper
// - Disable then enable clears pace counter
// - Control holds enable, divider, no-preamble
// - Enabled engine polls all 32 addresses
// - PHY read slow; service from timers
module mac_reset_init_control
	import mac_reset_init_pkg::*;
(
	input  wire logic              clk_sys,       // Peripheral clock
	input  wire logic              nrst,          // Sync reset, low
	input  wire logic              periph_enable, // From power_sleep_unit
	input  wire logic [ADDR_W-1:0] addr,          // Byte address
	input  wire logic [DATA_W-1:0] wdata,         // Write data
	input  wire logic              wr,            // Write strobe
	input  wire logic              rd,            // Read strobe
	output logic      [DATA_W-1:0] rdata,         // Read data, next cycle
	input  wire logic              rx_dma_idle,   // Receive DMA idle
	input  wire logic              tx_dma_idle,   // Transmit DMA idle
	input  wire logic              desc_err_evt,  // Descriptor error pulse
	input  wire logic [ERR_CODE_W-1:0] desc_err_code, // Its cause
	input  wire logic              core_irq_req,  // Core interrupt level
	output logic                   irq_out,       // Paced interrupt
	output logic                   descriptor_error_irq, // Latched error
	output logic                   core_rst_n,    // Core reset, low
	output logic                   rx_dma_enable, // Receive DMA on
	output logic                   tx_dma_enable, // Transmit DMA on
	output logic                   media_if_enable, // Media interface on
	output logic      [DATA_W-1:0] mac_ctrl_word, // Core control word
	input  wire logic              mdio_in,       // Management data in
	output logic                   mdio_out,      // Management data out
	output logic                   mdio_oe,       // Management drive
	output logic                   mdc            // Management clock
);

	// ****************************************
	// Enable synchroniser and local reset
	// ****************************************
	logic en_s1_ff;  // First stage, read only by the second
	logic en_s2_ff;  // Settled enable level

	// The power controller sits outside this clock's domain
	always_ff @(posedge clk_sys) begin
		en_s1_ff <= nrst ? periph_enable : 1'b0;
		en_s2_ff <= nrst ? en_s1_ff : 1'b0;
	end

	// Disabled counts as hardware reset, so enabling starts clean
	wire run = nrst && en_s2_ff;

	// ****************************************
	// Address decode
	// ****************************************
	wire in_desc   = addr[ADDR_W-1];
	wire hit_rst   = addr == OFF_CORE_RESET;
	wire hit_state = addr == OFF_MAC_STATE;
	wire hit_girq  = addr == OFF_GLOBAL_IRQ;
	wire hit_pace  = addr == OFF_IRQ_PACE;
	wire hit_mgmt  = addr == OFF_MGMT_CTRL;
	wire hit_alive = addr == OFF_MGMT_ALIVE;
	wire hit_mac   = addr == OFF_MAC_CTRL;
	wire hit_rx    = addr == OFF_RX_CTRL;
	wire hit_tx    = addr == OFF_TX_CTRL;
	wire wr_ok     = wr && run;
	wire [DESC_IDX_W-1:0] desc_idx = addr[DESC_IDX_W+1:2];

	// ****************************************
	// Core self-clearing reset
	// ****************************************
	logic core_pend_ff;  // Reset requested, not yet done
	logic core_rst_ff;   // One-cycle core reset pulse

	wire rst_wr    = wr_ok && hit_rst && wdata[CORE_RST_BIT];
	// Only fire once both engines are quiet, else the bus can hang
	wire rst_fire  = core_pend_ff && rx_dma_idle && tx_dma_idle;
	// A fresh request in the firing cycle stays pending
	wire nxt_core_pend = rst_wr || (core_pend_ff && !rst_fire);

	// Pending flag read back through the reset register
	always_ff @(posedge clk_sys) begin
		if (!run) begin
			core_pend_ff <= 1'b0;
			core_rst_ff  <= 1'b0;
		end else begin
			core_pend_ff <= nxt_core_pend;
			core_rst_ff  <= rst_fire;
		end
	end

	assign core_rst_n = !core_rst_ff && run;

	// ****************************************
	// Core registers, cleared by soft reset
	// ****************************************
	logic [DATA_W-1:0] mac_ctrl_ff;  // Core control word
	logic [DATA_W-1:0] rx_ctrl_ff;   // Receive control
	logic [DATA_W-1:0] tx_ctrl_ff;   // Transmit control

	// Soft reset reaches only this group; wrapper and engine
	// registers below have no register-driven reset
	always_ff @(posedge clk_sys) begin
		if (!run || core_rst_ff) begin
			mac_ctrl_ff <= WORD_ZERO;
			rx_ctrl_ff  <= WORD_ZERO;
			tx_ctrl_ff  <= WORD_ZERO;
		end else if (wr_ok) begin
			if (hit_mac) begin
				mac_ctrl_ff <= wdata;
			end
			if (hit_rx) begin
				rx_ctrl_ff <= wdata;
			end
			if (hit_tx) begin
				tx_ctrl_ff <= wdata;
			end
		end
	end

	assign mac_ctrl_word   = mac_ctrl_ff;
	assign media_if_enable = mac_ctrl_ff[MEDIA_EN_BIT];
	assign rx_dma_enable   = rx_ctrl_ff[DMA_EN_BIT];
	assign tx_dma_enable   = tx_ctrl_ff[DMA_EN_BIT];

	// ****************************************
	// Descriptor error latch
	// ****************************************
	logic                  err_ff;       // Latched error
	logic [ERR_CODE_W-1:0] err_code_ff;  // Cause of first error

	// Survives soft reset; only hardware reset or disable clears it
	always_ff @(posedge clk_sys) begin
		if (!run) begin
			err_ff      <= 1'b0;
			err_code_ff <= '0;
		end else if (desc_err_evt && !err_ff) begin
			err_ff      <= 1'b1;
			err_code_ff <= desc_err_code;
		end
	end

	assign descriptor_error_irq = err_ff;

	// ****************************************
	// Global enable and interrupt pacing
	// ****************************************
	logic              girq_en_ff;  // Global interrupt enable
	logic [DATA_W-1:0] pace_ff;     // Programmed retrigger count
	logic [DATA_W-1:0] pace_cnt_ff; // Remaining spacing
	logic              irq_ff;      // Output level

	// A new assertion is held off until the spacing has run out
	wire nxt_irq   = girq_en_ff && core_irq_req &&
			 (irq_ff || pace_cnt_ff == WORD_ZERO);
	wire irq_start = nxt_irq && !irq_ff;

	// Wrapper control registers
	always_ff @(posedge clk_sys) begin
		if (!run) begin
			girq_en_ff <= 1'b0;
			pace_ff    <= PACE_RST;
		end else if (wr_ok) begin
			if (hit_girq) begin
				girq_en_ff <= wdata[GIRQ_EN_BIT];
			end
			if (hit_pace) begin
				pace_ff <= wdata;
			end
		end
	end

	// Counter ticks on the peripheral clock itself; dropping the
	// enable clears it, which is why only the ISR should toggle it
	always_ff @(posedge clk_sys) begin
		if (!run || !girq_en_ff) begin
			pace_cnt_ff <= WORD_ZERO;
			irq_ff      <= 1'b0;
		end else begin
			irq_ff <= nxt_irq;
			if (irq_start) begin
				pace_cnt_ff <= pace_ff;
			end else if (pace_cnt_ff != WORD_ZERO) begin
				pace_cnt_ff <= pace_cnt_ff - 32'h0000_0001;
			end
		end
	end

	assign irq_out = irq_ff;

	// ****************************************
	// Management engine control
	// ****************************************
	logic                  mgmt_en_ff;     // Engine enable
	logic                  mgmt_nopre_ff;  // Skip preamble
	logic [MGMT_DIV_W-1:0] mgmt_div_ff;    // Clock divider

	// Divider is host-chosen; aim for roughly 1 MHz on the line
	always_ff @(posedge clk_sys) begin
		if (!run) begin
			mgmt_en_ff    <= 1'b0;
			mgmt_nopre_ff <= 1'b0;
			mgmt_div_ff   <= MGMT_DIV_RST;
		end else if (wr_ok && hit_mgmt) begin
			mgmt_en_ff    <= wdata[MGMT_EN_BIT];
			mgmt_nopre_ff <= wdata[MGMT_NOPRE_BIT];
			mgmt_div_ff   <= wdata[MGMT_DIV_W-1:0];
		end
	end

	mgmt_link_if mlink ();

	assign mlink.enable      = mgmt_en_ff;
	assign mlink.divider     = mgmt_div_ff;
	assign mlink.no_preamble = mgmt_nopre_ff;

	mgmt_poll_engine u_engine (
		.clk_sys  (clk_sys),
		.nrst     (run),
		.lnk      (mlink),
		.mdio_in  (mdio_in),
		.mdio_out (mdio_out),
		.mdio_oe  (mdio_oe),
		.mdc      (mdc)
	);

	// ****************************************
	// Descriptor RAM
	// ****************************************
	logic [DATA_W-1:0] desc_mem_ff [DESC_WORDS];  // Local 8K store

	// Data store only, so no reset; trades reset cost for area
	always_ff @(posedge clk_sys) begin
		if (wr_ok && in_desc) begin
			desc_mem_ff[desc_idx] <= wdata;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	logic [DATA_W-1:0] rdata_ff;  // Registered read data

	wire [DATA_W-1:0] state_word = {err_ff, 23'h000000, err_code_ff};
	wire [DATA_W-1:0] rst_word   = {31'h00000000, core_pend_ff};
	wire [DATA_W-1:0] girq_word  = {31'h00000000, girq_en_ff};
	wire [DATA_W-1:0] mgmt_word  = {1'b0, mgmt_en_ff, 9'h000,
					mgmt_nopre_ff, 4'h0, mgmt_div_ff};
	wire [DATA_W-1:0] rd_mux =
		in_desc   ? desc_mem_ff[desc_idx] :
		hit_rst   ? rst_word    :
		hit_state ? state_word  :
		hit_girq  ? girq_word   :
		hit_pace  ? pace_ff     :
		hit_mgmt  ? mgmt_word   :
		hit_alive ? mlink.alive :
		hit_mac   ? mac_ctrl_ff :
		hit_rx    ? rx_ctrl_ff  :
		hit_tx    ? tx_ctrl_ff  : WORD_ZERO;

	// Data stands only in the cycle after the strobe; disabled
	// peripheral and unmapped addresses read as zero
	always_ff @(posedge clk_sys) begin
		if (rd && run) begin
			rdata_ff <= rd_mux;
		end else begin
			rdata_ff <= WORD_ZERO;
		end
	end

	assign rdata = rdata_ff;

endmodule

// file: verif/mac_reset_init_control_checker.sv
// Port-level assertions for the MAC reset and bring-up block
`timescale 1ns/1ps
module mac_reset_init_control_checker
	import mac_reset_init_pkg::*;
(
	input wire logic              clk_sys,              // Clock
	input wire logic              nrst,                 // Sync reset, low
	input wire logic              periph_enable,        // Peripheral on
	input wire logic [ADDR_W-1:0] addr,                 // Byte address
	input wire logic [DATA_W-1:0] wdata,                // Write data
	input wire logic              wr,                   // Write strobe
	input wire logic              rd,                   // Read strobe
	input wire logic [DATA_W-1:0] rdata,                // Read data
	input wire logic              rx_dma_idle,          // Receive idle
	input wire logic              tx_dma_idle,          // Transmit idle
	input wire logic              desc_err_evt,         // Error pulse
	input wire logic              core_irq_req,         // Core request
	input wire logic              irq_out,              // Paced request
	input wire logic              descriptor_error_irq, // Error latch
	input wire logic              core_rst_n,           // Core reset
	input wire logic              rx_dma_enable,        // Receive on
	input wire logic              tx_dma_enable,        // Transmit on
	input wire logic              media_if_enable,      // Media on
	input wire logic              mdio_oe               // Pin drive
);
	// ****************************************
	// Helper logic
	// ****************************************
	default clocking dflt @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	logic [2:0] run_ff;  // Cycles since enable, saturating
	logic [2:0] nxt_run; // Next count
	wire        settled = (run_ff == 3'h7); // Past the enable sync
	wire        rst_wr  = wr && addr == OFF_CORE_RESET && wdata[CORE_RST_BIT];
	wire        rst_rd  = rd && addr == OFF_CORE_RESET;
	wire        idle    = rx_dma_idle && tx_dma_idle;
	assign nxt_run = (!nrst || !periph_enable) ? 3'h0 :
			 settled ? run_ff : run_ff + 3'h1;
	// Counter keeps checks away from the two-stage enable sync
	always_ff @(posedge clk_sys) begin
		run_ff <= nxt_run;
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence soft_go;
		settled && rst_wr ##1 idle && !wr;
	endsequence
	sequence poll_twice;
		rst_rd ##1 rst_rd;
	endsequence

	AST_READ_SLOT: assert property (!$past(rd) |-> rdata == WORD_ZERO)
		else $error("read data outside its slot");
	AST_DIS_READ: assert property (
		!periph_enable[*3] ##0 rd |=> rdata == WORD_ZERO)
		else $error("read while disabled not zero");
	AST_DIS_DEFAULTS: assert property (!periph_enable[*4] |->
		!core_rst_n && !irq_out && !rx_dma_enable && !tx_dma_enable
		&& !media_if_enable && !mdio_oe)
		else $error("disabled block not at defaults");
	AST_SOFT_PULSE: assert property (soft_go |=> !core_rst_n ##1 core_rst_n)
		else $error("core reset pulse wrong");
	AST_SOFT_WAIT: assert property (settled && !idle |=> core_rst_n)
		else $error("core reset while DMA busy");
	AST_PEND_READ: assert property (
		soft_go ##0 poll_twice |-> rdata[CORE_RST_BIT] ##1 !rdata[CORE_RST_BIT])
		else $error("reset bit poll wrong");
	AST_ERR_SET: assert property (
		settled && desc_err_evt |=> descriptor_error_irq)
		else $error("descriptor error not latched");
	AST_ERR_HOLD: assert property (
		settled && descriptor_error_irq |=> descriptor_error_irq)
		else $error("descriptor error dropped");
	AST_IRQ_CAUSE: assert property (!core_irq_req |=> !irq_out)
		else $error("interrupt without request");
endmodule

bind mac_reset_init_control mac_reset_init_control_checker chk (
	.clk_sys(clk_sys), .nrst(nrst), .periph_enable(periph_enable),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.rx_dma_idle(rx_dma_idle), .tx_dma_idle(tx_dma_idle),
	.desc_err_evt(desc_err_evt), .core_irq_req(core_irq_req),
	.irq_out(irq_out), .descriptor_error_irq(descriptor_error_irq),
	.core_rst_n(core_rst_n), .rx_dma_enable(rx_dma_enable),
	.tx_dma_enable(tx_dma_enable), .media_if_enable(media_if_enable),
	.mdio_oe(mdio_oe));

// file: verif/phy_mgmt_model.sv
// Behavioural PHY answering management reads at one bus address
`timescale 1ns/1ps
module phy_mgmt_model #(
	parameter logic [4:0]  PHY_AT   = 5'h05,   // Bus address of this PHY
	parameter logic [15:0] REG_DATA = 16'h1234 // Value of any register
) (
	input  wire logic mdc,      // Management clock
	input  wire logic mdio_out, // Host data
	input  wire logic mdio_oe,  // Host drive enable
	output logic      mdio_in   // Resolved line level
);
	logic [13:0] hdr_ff  = 14'h3FFF; // Start, op, address, register
	logic [4:0]  step_ff = 5'h1F;    // Clocks since host let go
	wire         own     = (hdr_ff[9:5] == PHY_AT);
	wire         drv     = own && step_ff >= 5'h01 && step_ff <= 5'h11;
	wire         bit_v   = (step_ff < 5'h02) ? 1'b0 : REG_DATA[5'h11 - step_ff];
	// Pull-up on the line, so a released line reads high
	assign mdio_in = mdio_oe ? mdio_out : (drv ? bit_v : 1'b1);
	// Header is the last bits shifted in, with or without preamble
	always @(posedge mdc) begin
		if (mdio_oe) begin
			hdr_ff <= {hdr_ff[12:0], mdio_out};
			step_ff <= 5'h00;
		end else if (step_ff != 5'h1F) begin
			step_ff <= step_ff + 5'h01;
		end
	end
endmodule

// file: verif/mac_reset_init_control_test.sv
// Register-level testbench for the MAC reset and bring-up block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin \
	tests_run++; \
	if ((s) !== (e)) begin \
		error_cnt++; \
		$display("BAD %s exp %h got %h", nm, e, s); \
	end \
end
module mac_reset_init_control_test;
	import mac_reset_init_pkg::*;
	localparam logic [4:0] PHY_AT = 5'h05; // Model's bus address
	logic                  clk_sys, nrst, periph_enable, wr, rd;
	logic                  rx_dma_idle, tx_dma_idle, desc_err_evt;
	logic                  core_irq_req, mdio_in, mdio_out, mdio_oe, mdc;
	logic                  irq_out, descriptor_error_irq, core_rst_n;
	logic                  rx_dma_enable, tx_dma_enable, media_if_enable;
	logic [ADDR_W-1:0]     addr;          // Bus address
	logic [DATA_W-1:0]     wdata, rdata, mcw; // Bus data, core word
	logic [ERR_CODE_W-1:0] desc_err_code; // Error cause
	logic [31:0]           v;             // Polled value
	int                    error_cnt, tests_run, n;

	mac_reset_init_control dut (.clk_sys(clk_sys), .nrst(nrst),
		.periph_enable(periph_enable), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .rx_dma_idle(rx_dma_idle),
		.tx_dma_idle(tx_dma_idle), .desc_err_evt(desc_err_evt),
		.desc_err_code(desc_err_code), .core_irq_req(core_irq_req),
		.irq_out(irq_out), .descriptor_error_irq(descriptor_error_irq),
		.core_rst_n(core_rst_n), .rx_dma_enable(rx_dma_enable),
		.tx_dma_enable(tx_dma_enable), .media_if_enable(media_if_enable),
		.mac_ctrl_word(mcw), .mdio_in(mdio_in), .mdio_out(mdio_out),
		.mdio_oe(mdio_oe), .mdc(mdc));
	phy_mgmt_model #(.PHY_AT(PHY_AT)) phy (.mdc(mdc),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdio_in(mdio_in));

	// ****************************************
	// Clock, watchdog and bus tasks
	// ****************************************
	always #50 clk_sys = ~clk_sys;
	// Whole run needs some 14000 cycles; a hang is cut well after
	initial begin
		repeat (80000) @(posedge clk_sys);
		error_cnt++;
		report_and_stop();
	end
	task report_and_stop;
		if (error_cnt == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task hw_reset;
		@(posedge clk_sys);
		nrst <= 1'b0;
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
	endtask
	task wr_reg(input logic [13:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	task rd_raw(input logic [13:0] a, output logic [31:0] q);
		@(posedge clk_sys);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd <= 1'b0;
		@(negedge clk_sys);
		q = rdata;
		@(posedge clk_sys);
	endtask
	task rd_reg(input logic [13:0] a, input logic [31:0] e);
		logic [31:0] q;
		rd_raw(a, q);
		`CHK($sformatf("reg %h", a), e, q)
	endtask
	// Soft reset with DMA idle, then two back-to-back polls
	task soft_poll;
		wr_reg(OFF_CORE_RESET, 32'h0000_0001);
		rd <= 1'b1;
		@(posedge clk_sys);
		@(negedge clk_sys);
		`CHK("reset pending", 1'b1, rdata[CORE_RST_BIT])
		`CHK("core reset low", 1'b0, core_rst_n)
		@(posedge clk_sys);
		rd <= 1'b0;
		@(negedge clk_sys);
		`CHK("reset done", 1'b0, rdata[CORE_RST_BIT])
		`CHK("core reset n", 1'b1, core_rst_n)
		@(posedge clk_sys);
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		{clk_sys, nrst, wr, rd, desc_err_evt, core_irq_req} = '0;
		{periph_enable, rx_dma_idle, tx_dma_idle} = 3'b111;
		{addr, wdata, desc_err_code, error_cnt, tests_run} = '0;
		hw_reset();
		rd_reg(OFF_MGMT_CTRL, {16'h0000, MGMT_DIV_RST});
		rd_reg(OFF_IRQ_PACE, PACE_RST);
		rd_reg(14'h0100, WORD_ZERO);
		// Ordered bring-up, media enable after both DMAs
		// Counter, station, unicast setup is outside
		wr_reg(OFF_GLOBAL_IRQ, WORD_ZERO);
		wr_reg(OFF_MAC_CTRL, WORD_ZERO);
		wr_reg(OFF_IRQ_PACE, 32'h0000_0040);
		wr_reg(OFF_DESC_BASE + 14'h1FFC, 32'hA5A5_5A5A);
		wr_reg(OFF_RX_CTRL, 32'h1 << DMA_EN_BIT);
		wr_reg(OFF_TX_CTRL, 32'h1 << DMA_EN_BIT);
		wr_reg(OFF_MAC_CTRL, 32'h1 << MEDIA_EN_BIT);
		wr_reg(OFF_GLOBAL_IRQ, 32'h1 << GIRQ_EN_BIT);
		`CHK("enables", 3'b111, {rx_dma_enable, tx_dma_enable, media_if_enable})
		`CHK("mac word", 32'h1 << MEDIA_EN_BIT, mcw)
		// Soft reset held off while receive DMA is busy
		rx_dma_idle <= 1'b0;
		wr_reg(OFF_CORE_RESET, 32'h0000_0001);
		repeat (8) @(posedge clk_sys);
		rd_reg(OFF_CORE_RESET, 32'h0000_0001);
		`CHK("core reset n", 1'b1, core_rst_n)
		rx_dma_idle <= 1'b1;
		rd_reg(OFF_CORE_RESET, WORD_ZERO);
		rd_reg(OFF_MAC_CTRL, WORD_ZERO);
		rd_reg(OFF_TX_CTRL, WORD_ZERO);
		rd_reg(OFF_GLOBAL_IRQ, 32'h1 << GIRQ_EN_BIT);
		rd_reg(OFF_IRQ_PACE, 32'h0000_0040);
		rd_reg(OFF_DESC_BASE + 14'h1FFC, 32'hA5A5_5A5A);
		wr_reg(OFF_RX_CTRL, 32'h1 << DMA_EN_BIT);
		soft_poll();
		rd_reg(OFF_RX_CTRL, WORD_ZERO);
		// Pacing spaces a second request; enable toggle clears it
		core_irq_req <= 1'b1;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		`CHK("irq first", 1'b1, irq_out)
		@(posedge clk_sys);
		core_irq_req <= 1'b0;
		repeat (2) @(posedge clk_sys);
		core_irq_req <= 1'b1;
		repeat (20) @(posedge clk_sys);
		`CHK("irq spaced", 1'b0, irq_out)
		wr_reg(OFF_GLOBAL_IRQ, WORD_ZERO);
		wr_reg(OFF_GLOBAL_IRQ, 32'h1 << GIRQ_EN_BIT);
		repeat (2) @(posedge clk_sys);
		`CHK("irq after toggle", 1'b1, irq_out)
		core_irq_req <= 1'b0;
		// Back-to-back errors keep the first code through soft reset
		desc_err_evt <= 1'b1;
		desc_err_code <= 8'h5A;
		@(posedge clk_sys);
		desc_err_code <= 8'h33;
		@(posedge clk_sys);
		desc_err_evt <= 1'b0;
		soft_poll();
		rd_reg(OFF_MAC_STATE, (32'h1 << ERR_FLAG_BIT) | 32'h5A);
		hw_reset();
		`CHK("error latch", 1'b0, descriptor_error_irq)
		rd_reg(OFF_MAC_STATE, WORD_ZERO);
		// Engine sweeps all addresses; only the model answers
		wr_reg(OFF_MGMT_CTRL, 32'h4010_0003);
		rd_reg(OFF_MGMT_CTRL, 32'h4010_0003);
		n = 0;
		do begin
			rd_raw(OFF_MGMT_ALIVE, v);
			n++;
		end while (v[PHY_AT] !== 1'b1 && n < 4000);
		repeat (12000) @(posedge clk_sys);
		rd_reg(OFF_MGMT_ALIVE, 32'h1 << PHY_AT);
		// Disabled: writes dropped, reads zero, defaults on enable
		periph_enable <= 1'b0;
		repeat (4) @(posedge clk_sys);
		wr_reg(OFF_MAC_CTRL, 32'h1 << MEDIA_EN_BIT);
		rd_reg(OFF_MGMT_CTRL, WORD_ZERO);
		periph_enable <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd_reg(OFF_MAC_CTRL, WORD_ZERO);
		rd_reg(OFF_MGMT_CTRL, {16'h0000, MGMT_DIV_RST});
		rd_reg(OFF_MGMT_ALIVE, WORD_ZERO);
		report_and_stop();
	end
endmodule
